/* File: shared/slsd_pkg.sv */
/*
 * Constants, field layout and state codes shared by the serial LCD segment driver.
 * Assumes a single 50 MHz system clock and pins that arrive asynchronously.
 */
// What this block does
// R01: Serial input is accepted only while select is high for the whole frame.
// R02: Each shift clock rise with select high shifts one data bit into 72 stages.
// R03: Select falling moves the frame into the addressed group latches and display; code holds it in the buffer to a frame start, drops it when full.
// R04: The shift register keeps its contents however long the shift clock pauses.
// R05: Role pin high selects master, low selects slave.
// R06: Master drives frame align; slave reads it and aligns its common sequence.
// R07: Master times from its own oscillator; slave times from the rc clock pin.
// R08: Tick output runs at the oscillator rate divided by four.
// R09: Slaves follow the master common rate and sync to run in lockstep.
// R10: Duty pin high selects half duty, low selects third duty.
// R11: Half duty multiplexes only the first two backplane drives.
// R12: Lamp test low turns every column drive on.
// R13: Display off low turns every column drive off.
// R14: Half duty frame is 48 bits; even bits first common, odd bits second.
// R15: Third duty frame is 72 bits; bit triples map to the three commons.
// R16: Last three bits are a group address, one bit each for segments 0-20, 21-41, 42-61.
// R17: Several address bits set load the same data into every selected group.
// R18: Half duty ignores dummy bits 42-44, and 40-44 for the last group.
// R19: Third duty ignores dummy bits 63-68, and 60-68 for the last group.
// R20: Host may drop leading bits but always ends with the address bits.
// R21: When lamp test and display off are both low, display off wins.
// R22: Group latches count as undefined until each group is written once.
package slsd_pkg;

    // =====================================================================
    // Frame layout.
    localparam int SLSD_SR_LEN = 72;
    localparam int SLSD_HALF_LEN = 48;
    localparam int SLSD_SEG_NUM = 62;
    localparam int SLSD_COM_NUM = 3;
    localparam int SLSD_GRP_SIZE = 21;
    localparam int SLSD_ADDR_BITS = 3;
    localparam int SLSD_HALF_STEP = 2;
    localparam int SLSD_THIRD_STEP = 3;
    localparam int SLSD_FIFO_DEPTH = 8;

    // =====================================================================
    // Timing.
    localparam int SLSD_CLK_HZ = 50_000_000;
    localparam int SLSD_OSC_HZ = 1400;
    localparam int SLSD_OSC_DIV_CYC = SLSD_CLK_HZ / SLSD_OSC_HZ;
    localparam int SLSD_OSC_CNT_W = 16;
    localparam int SLSD_TICK_DIV = 4;
    localparam int SLSD_PRE_W = $clog2(SLSD_TICK_DIV);
    localparam logic [SLSD_PRE_W-1:0] SLSD_PRE_LAST = SLSD_PRE_W'(SLSD_TICK_DIV - 1);
    localparam logic [1:0] SLSD_HALF_COMS = 2'h2;
    localparam logic [1:0] SLSD_THIRD_COMS = 2'h3;

    // =====================================================================
    // Synchronised pin vector layout and its reset value.
    localparam int SLSD_IN_SEL = 0;
    localparam int SLSD_IN_SCK = 1;
    localparam int SLSD_IN_DAT = 2;
    localparam int SLSD_IN_ROLE = 3;
    localparam int SLSD_IN_DUTY = 4;
    localparam int SLSD_IN_LAMP = 5;
    localparam int SLSD_IN_OFF = 6;
    localparam int SLSD_IN_RC = 7;
    localparam int SLSD_IN_ALIGN = 8;
    localparam int SLSD_IN_NUM = 9;
    localparam logic [SLSD_IN_NUM-1:0] SLSD_IN_RST = 9'h160;

    // =====================================================================
    // Serial port states.
    typedef enum logic [1:0]
    {
        SLSD_IDLE = 2'h1,
        SLSD_SHIFT = 2'h2
    } slsd_port_state_type;

endpackage : slsd_pkg

/* File: hw/slsd_fifo.sv */
/*
 * Frame buffer between the serial port and the display latches.
 * Assumes one clock; the drain side may stall for long periods.
 */
`timescale 1ns/1ps
module slsd_fifo #(
    parameter int WIDTH = 72,
    parameter int DEPTH = 8
) (
    input wire logic i_clk_sys,
    input wire logic i_rst,
    input wire logic i_in_valid,
    output logic o_in_ready,
    input wire logic [WIDTH-1:0] i_in_data,
    output logic o_out_valid,
    input wire logic i_out_ready,
    output logic [WIDTH-1:0] o_out_data
);
    import slsd_pkg::*;

    localparam int PW = $clog2(DEPTH);
    localparam int CW = $clog2(DEPTH + 1);
    localparam logic [PW-1:0] PTR_LAST = PW'(DEPTH - 1);
    localparam logic [CW-1:0] CNT_FULL = CW'(DEPTH);
    localparam logic [CW-1:0] CNT_LAST = CW'(DEPTH - 1);

    typedef struct packed {
        logic [DEPTH-1:0][WIDTH-1:0] mem;
        logic [PW-1:0] wp;
        logic [PW-1:0] rp;
        logic [CW-1:0] cnt;
        logic [WIDTH-1:0] head;
        logic head_v;
    } slsd_fifo_state_type;

    slsd_fifo_state_type r;
    slsd_fifo_state_type n;

    // =====================================================================
    // Storage plus a registered head word.
    // The head word counts toward the depth, so the buffer holds DEPTH words in all.
    assign o_in_ready = r.head_v ? (r.cnt != CNT_LAST) : (r.cnt != CNT_FULL);
    assign o_out_valid = r.head_v;
    assign o_out_data = r.head;

    always_comb
    begin
        n = r;
        if (i_in_valid && o_in_ready)
        begin
            n.mem[r.wp] = i_in_data;
            n.wp = (r.wp == PTR_LAST) ? '0 : PW'(r.wp + 1'b1);
            n.cnt = CW'(r.cnt + 1'b1);
        end
        if (!r.head_v || i_out_ready)
        begin
            if (n.cnt != '0)
            begin
                n.head = n.mem[r.rp];
                n.head_v = 1'b1;
                n.rp = (r.rp == PTR_LAST) ? '0 : PW'(r.rp + 1'b1);
                n.cnt = CW'(n.cnt - 1'b1);
            end
            else
            begin
                n.head_v = 1'b0;
            end
        end
    end

    always_ff @(posedge i_clk_sys)
    begin
        if (i_rst)
        begin
            r <= '0;
        end
        else
        begin
            r <= n;
        end
    end

endmodule : slsd_fifo

/* File: hw/slsd_top.sv */
/*
 * Serial LCD segment driver: serial frame port, group latches, common
 * sequencing, master and slave synchronisation, lamp test and blanking.
 * Assumes every pin input is asynchronous to the 50 MHz system clock.
 */
`timescale 1ns/1ps
module slsd_top #(
    parameter int OSC_DIV = slsd_pkg::SLSD_OSC_DIV_CYC,
    parameter int FIFO_DEPTH = slsd_pkg::SLSD_FIFO_DEPTH
) (
    input wire logic i_clk_sys,
    input wire logic i_rst,
    input wire logic i_select_in,
    input wire logic i_shift_clock,
    input wire logic i_data,
    input wire logic i_role_pick,
    input wire logic i_duty_pick,
    input wire logic i_lamp_test_n,
    input wire logic i_display_off_n,
    input wire logic i_rc_clock_pin,
    input wire logic i_frame_align,
    output logic o_frame_align,
    output logic o_frame_align_oe_n,
    output logic o_tick_out,
    output logic o_frame_ready,
    output logic [slsd_pkg::SLSD_COM_NUM-1:0] o_backplane_drives,
    output logic [slsd_pkg::SLSD_SEG_NUM-1:0] o_glass_column_drives,
    output logic [slsd_pkg::SLSD_COM_NUM-1:0] o_groups_loaded
);
    import slsd_pkg::*;

    // =====================================================================
    // State.
    typedef struct packed {
        logic [SLSD_IN_NUM-1:0] s1;
        logic [SLSD_IN_NUM-1:0] s2;
        logic [SLSD_IN_NUM-1:0] s3;
        logic [SLSD_IN_NUM-1:0] q;
        slsd_port_state_type st;
        logic [SLSD_SR_LEN-1:0] sr;
        logic [SLSD_OSC_CNT_W-1:0] osc_cnt;
        logic [SLSD_PRE_W-1:0] pre;
        logic [1:0] phase;
        logic [SLSD_COM_NUM-1:0][SLSD_SEG_NUM-1:0] lat;
        logic [SLSD_COM_NUM-1:0] loaded;
        logic [SLSD_COM_NUM-1:0] com;
        logic [SLSD_SEG_NUM-1:0] col;
        logic sync_o;
        logic oe_n;
    } slsd_top_state_type;

    localparam slsd_top_state_type ST_RST = '{
        s1: SLSD_IN_RST,
        s2: SLSD_IN_RST,
        s3: SLSD_IN_RST,
        q: SLSD_IN_RST,
        st: SLSD_IDLE,
        sr: '0,
        osc_cnt: '0,
        pre: '0,
        phase: '0,
        lat: '0,
        loaded: '0,
        com: '0,
        col: '0,
        sync_o: 1'b1,
        oe_n: 1'b1
    };

    localparam logic [SLSD_OSC_CNT_W-1:0] OSC_LAST = SLSD_OSC_CNT_W'(OSC_DIV - 1);

    slsd_top_state_type r;
    slsd_top_state_type n;

    logic [SLSD_IN_NUM-1:0] pins_w;
    logic [SLSD_IN_NUM-1:0] agree_w;
    logic [SLSD_IN_NUM-1:0] q_w;
    logic [SLSD_IN_NUM-1:0] rise_w;
    logic [SLSD_IN_NUM-1:0] fall_w;
    logic role_w;
    logic duty_w;
    logic lamp_w;
    logic off_w;
    logic dat_w;
    logic shift_w;
    logic push_w;
    logic osc_tick_w;
    logic adv_w;
    logic frame_start_w;
    logic pop_w;
    logic [1:0] ncom_w;
    logic fifo_in_rdy;
    logic fifo_out_v;
    logic [SLSD_SR_LEN-1:0] fifo_out_d;

    // =====================================================================
    // Pin synchronisers: a change counts once stages two and three agree.
    assign pins_w = {i_frame_align, i_rc_clock_pin, i_display_off_n, i_lamp_test_n,
                     i_duty_pick, i_role_pick, i_data, i_shift_clock, i_select_in};
    assign agree_w = ~(r.s2 ^ r.s3);
    assign q_w = (agree_w & r.s3) | (~agree_w & r.q);
    assign rise_w = q_w & ~r.q;
    assign fall_w = ~q_w & r.q;

    assign role_w = q_w[SLSD_IN_ROLE];
    assign duty_w = q_w[SLSD_IN_DUTY];
    assign lamp_w = q_w[SLSD_IN_LAMP];
    assign off_w = q_w[SLSD_IN_OFF];
    assign dat_w = q_w[SLSD_IN_DAT];

    // =====================================================================
    // Serial port strobes.
    assign shift_w = (r.st == SLSD_SHIFT) && rise_w[SLSD_IN_SCK] && q_w[SLSD_IN_SEL]; // R01
    assign push_w = (r.st == SLSD_SHIFT) && fall_w[SLSD_IN_SEL]; // R03

    // =====================================================================
    // Display timing strobes.
    // A slave steps one common per falling master tick, which falls as the master steps.
    assign osc_tick_w = role_w ? (r.osc_cnt == OSC_LAST) : fall_w[SLSD_IN_RC]; // R07
    assign adv_w = osc_tick_w && (!role_w || (r.pre == SLSD_PRE_LAST)); // R09
    assign ncom_w = duty_w ? SLSD_HALF_COMS : SLSD_THIRD_COMS; // R10
    assign pop_w = frame_start_w && fifo_out_v;

    // =====================================================================
    // Frame buffer; a frame is only taken into the latches at a frame start.
    slsd_fifo #(
        .WIDTH(SLSD_SR_LEN),
        .DEPTH(FIFO_DEPTH)
    ) u_fifo (
        .i_clk_sys(i_clk_sys),
        .i_rst(i_rst),
        .i_in_valid(push_w),
        .o_in_ready(fifo_in_rdy),
        .i_in_data(r.sr),
        .o_out_valid(fifo_out_v),
        .i_out_ready(frame_start_w),
        .o_out_data(fifo_out_d)
    );

    // =====================================================================
    // Next state.
    always_comb
    begin
        int g;
        int i;
        int k;
        g = 0;
        i = 0;
        k = 0;
        n = r;
        frame_start_w = 1'b0;
        n.s1 = pins_w;
        n.s2 = r.s1;
        n.s3 = r.s2;
        n.q = q_w;

        // Serial port.
        case (r.st)
            SLSD_IDLE:
            begin
                if (rise_w[SLSD_IN_SEL])
                begin
                    n.st = SLSD_SHIFT; // R01
                end
            end
            SLSD_SHIFT:
            begin
                if (shift_w)
                begin
                    n.sr = {r.sr[SLSD_SR_LEN-2:0], dat_w}; // R02
                end
                if (fall_w[SLSD_IN_SEL])
                begin
                    n.st = SLSD_IDLE; // R03
                end
            end
            default:
            begin
                n.st = SLSD_IDLE;
            end
        endcase

        // Oscillator, tick divider and common phase.
        if (role_w)
        begin
            n.osc_cnt = osc_tick_w ? '0 : SLSD_OSC_CNT_W'(r.osc_cnt + 1'b1); // R07
        end
        else
        begin
            n.osc_cnt = '0;
        end
        if (osc_tick_w)
        begin
            n.pre = SLSD_PRE_W'(r.pre + 1'b1); // R08
        end
        if (r.phase >= ncom_w)
        begin
            n.phase = '0; // R11
        end
        else if (adv_w)
        begin
            n.phase = (r.phase == 2'(ncom_w - 2'h1)) ? '0 : 2'(r.phase + 2'h1); // R09
            frame_start_w = (n.phase == '0);
        end
        if (!role_w && fall_w[SLSD_IN_ALIGN])
        begin
            n.phase = '0; // R06
            n.pre = '0;
        end

        // Group latch load from the buffered frame.
        if (frame_start_w && fifo_out_v)
        begin
            for (int s = 0; s < SLSD_SEG_NUM; s++)
            begin
                g = s / SLSD_GRP_SIZE;
                i = s - g * SLSD_GRP_SIZE;
                if (fifo_out_d[SLSD_ADDR_BITS-1-g]) // R16 R17 R20
                begin
                    for (int c = 0; c < SLSD_COM_NUM; c++)
                    begin
                        if (duty_w && c < SLSD_HALF_STEP)
                        begin
                            k = SLSD_HALF_LEN - 1 - (SLSD_HALF_STEP * i + c); // R14 R18
                            n.lat[c][s] = fifo_out_d[k];
                        end
                        else if (!duty_w)
                        begin
                            k = SLSD_SR_LEN - 1 - (SLSD_THIRD_STEP * i + c); // R15 R19
                            n.lat[c][s] = fifo_out_d[k];
                        end
                    end
                end
            end
            for (int a = 0; a < SLSD_COM_NUM; a++)
            begin
                if (fifo_out_d[SLSD_ADDR_BITS-1-a])
                begin
                    n.loaded[a] = 1'b1; // R22
                end
            end
        end

        // Drive outputs.
        if (!off_w)
        begin
            n.col = '0; // R13 R21
        end
        else if (!lamp_w)
        begin
            n.col = '1; // R12
        end
        else
        begin
            n.col = n.lat[n.phase];
        end
        n.com = '0;
        n.com[n.phase] = 1'b1; // R11
        n.sync_o = (n.phase != '0) || !role_w; // R06
        n.oe_n = !role_w; // R05
    end

    always_ff @(posedge i_clk_sys)
    begin
        if (i_rst)
        begin
            r <= ST_RST;
        end
        else
        begin
            r <= n;
        end
    end

    // =====================================================================
    // Outputs.
    assign o_frame_align = r.sync_o;
    assign o_frame_align_oe_n = r.oe_n;
    assign o_tick_out = r.pre[SLSD_PRE_W-1]; // R08
    assign o_frame_ready = fifo_in_rdy;
    assign o_backplane_drives = r.com;
    assign o_glass_column_drives = r.col;
    assign o_groups_loaded = r.loaded;

    // =====================================================================
    // Checks.
    default clocking cb @(posedge i_clk_sys);
    endclocking
    default disable iff (i_rst);

    sequence s_sel_drop;
        (r.st == SLSD_SHIFT) ##0 fall_w[SLSD_IN_SEL];
    endsequence

    sequence s_slave_sync;
        !role_w ##0 fall_w[SLSD_IN_ALIGN];
    endsequence

    a_shift_gated: // R01
        assert property (!$stable(r.sr) |-> $past(shift_w))
        else $error("Shift register moved without an accepted shift edge.");

    a_shift_bit: // R02
        assert property (shift_w |=> r.sr[0] == $past(dat_w))
        else $error("Shifted bit does not match the data pin.");

    a_frame_close: // R03
        assert property (s_sel_drop |=> (r.st == SLSD_IDLE) && $stable(r.sr))
        else $error("Frame not closed cleanly on select falling.");

    a_sr_static: // R04
        assert property (!shift_w |=> $stable(r.sr))
        else $error("Shift register lost its contents while idle.");

    a_role_drive: // R05
        assert property (role_w |=> !o_frame_align_oe_n)
        else $error("Master does not drive frame align.");

    a_slave_lock: // R06
        assert property (s_slave_sync |=> (r.phase == '0) && (r.pre == '0))
        else $error("Slave did not realign to frame align.");

    a_tick_rate: // R08
        assert property ($rose(o_tick_out) |-> $past(osc_tick_w))
        else $error("Tick output moved without an oscillator tick.");

    a_half_coms: // R11
        assert property (duty_w [*2] |=> !o_backplane_drives[SLSD_COM_NUM-1])
        else $error("Third common active in half duty.");

    a_blank_wins: // R13
        assert property (!off_w |=> o_glass_column_drives == '0)
        else $error("Columns not blanked while display off is low.");

    a_lamp_on: // R12
        assert property (off_w && !lamp_w |=> &o_glass_column_drives)
        else $error("Columns not all on during lamp test.");

    a_group_load: // R22
        assert property (pop_w && fifo_out_d[SLSD_ADDR_BITS-1] |=> r.loaded[0])
        else $error("First group not marked loaded after its write.");

endmodule : slsd_top

/* File: verification/slsd_host.sv */
/*
 * Host model: drives select, shift clock and data of the serial frame port.
 * Assumes the system clock is given; every pin changes at its falling edge.
 */
`timescale 1ns/1ps
module slsd_host (
    input wire logic i_clk_sys,
    output logic o_select_in,
    output logic o_shift_clock,
    output logic o_data
);
    initial
    begin
        o_select_in = 1'b0;
        o_shift_clock = 1'b0;
        o_data = 1'b0;
    end

    task automatic hold(input int n);
        repeat (n) @(negedge i_clk_sys);
    endtask : hold

    // Sends the last nb bits of a frame of length len, lowest index first.
    task automatic send_frame(input logic [71:0] fr, input int len, input int nb,
                              input bit pause);
        hold(1);
        o_select_in = 1'b1;
        hold(6);
        for (int k = len - nb; k < len; k++)
        begin
            o_data = fr[k];
            hold(6);
            o_shift_clock = 1'b1;
            hold(6);
            o_shift_clock = 1'b0;
            if (pause && k == len - 10)
                hold(60);
        end
        hold(6);
        o_select_in = 1'b0;
        o_data = ~o_data;
        hold(6);
    endtask : send_frame
endmodule : slsd_host

/* File: verification/slsd_top_bench.sv */
/*
 * Bench for the serial LCD segment driver: frames, image model, test pins,
 * master and slave timing and buffer back-pressure.
 * Assumes the package and the host model are compiled first.
 */
`timescale 1ns/1ps
`define CHK(got, exp) \
    begin \
        compares++; \
        if ((got) !== (exp)) \
        begin \
            error_cnt++; \
            $display("[ERR] %0t: got %h expected %h", $time, got, exp); \
        end \
    end
module slsd_top_bench;
    import slsd_pkg::*;
    localparam int OSC = 8;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic role = 1'b1;
    logic duty = 1'b0;
    logic lamp_n = 1'b1;
    logic off_n = 1'b1;
    logic rc = 1'b0;
    logic rc_run = 1'b0;
    logic align_drv = 1'b1;
    logic sel, sck, dat, align_o, align_oe_n, tick, ready;
    logic [2:0] bp, loaded;
    logic [61:0] cols;
    logic [71:0] sr_m = '0;
    logic [2:0] img [62];
    int error_cnt = 0;
    int compares = 0;

    // =====================================================================
    // Clocks and instances.
    always #10 clk = ~clk;
    always
    begin
        repeat (4) @(negedge clk);
        if (rc_run)
            rc = ~rc;
    end
    slsd_host u_slsd_host (.i_clk_sys(clk), .o_select_in(sel), .o_shift_clock(sck),
        .o_data(dat));
    slsd_top #(.OSC_DIV(OSC), .FIFO_DEPTH(SLSD_FIFO_DEPTH)) u_slsd_top (
        .i_clk_sys(clk), .i_rst(rst), .i_select_in(sel), .i_shift_clock(sck),
        .i_data(dat), .i_role_pick(role), .i_duty_pick(duty), .i_lamp_test_n(lamp_n),
        .i_display_off_n(off_n), .i_rc_clock_pin(rc),
        .i_frame_align(align_oe_n ? align_drv : align_o), .o_frame_align(align_o),
        .o_frame_align_oe_n(align_oe_n), .o_tick_out(tick), .o_frame_ready(ready),
        .o_backplane_drives(bp), .o_glass_column_drives(cols), .o_groups_loaded(loaded));

    // =====================================================================
    // Tasks.
    task automatic cyc(input int n);
        repeat (n) @(negedge clk);
    endtask : cyc

    function automatic logic [71:0] mk(input logic [71:0] d, input bit half,
                                       input logic [2:0] a);
        int len;
        len = half ? SLSD_HALF_LEN : SLSD_SR_LEN;
        for (int k = 0; k < 3; k++)
            d[len - 1 - k] = a[k];
        return d;
    endfunction : mk

    // Loads the image model from the shift model as the addressed latches do.
    task automatic apply(input bit half);
        int len;
        int st;
        int g;
        len = half ? SLSD_HALF_LEN : SLSD_SR_LEN;
        st = half ? SLSD_HALF_STEP : SLSD_THIRD_STEP;
        for (int n = 0; n < SLSD_SEG_NUM; n++)
        begin
            g = n / SLSD_GRP_SIZE;
            for (int c = 0; c < st; c++)
                if (sr_m[2 - g])
                    img[n][c] = sr_m[len - 1 - st * (n - SLSD_GRP_SIZE * g) - c];
        end
    endtask : apply

    task automatic frame(input logic [71:0] d, input bit half, input logic [2:0] a,
                         input int nb, input bit pause);
        logic ok;
        logic [71:0] fr;
        int len;
        ok = ready;
        fr = mk(d, half, a);
        len = half ? SLSD_HALF_LEN : SLSD_SR_LEN;
        for (int k = len - nb; k < len; k++)
            sr_m = {sr_m[70:0], fr[k]};
        u_slsd_host.send_frame(fr, len, nb, pause);
        if (ok === 1'b1)
            apply(half);
    endtask : frame

    task automatic wait_com(input logic [2:0] v);
        int n;
        n = 0;
        while (bp !== v && n < 300)
        begin
            @(negedge clk);
            n++;
        end
        `CHK(bp, v)
    endtask : wait_com

    task automatic check_cols(input bit half);
        logic [61:0] e;
        logic seen;
        seen = 1'b0;
        for (int c = 0; c < (half ? 2 : 3); c++)
        begin
            wait_com(3'(1 << c));
            cyc(2);
            for (int n = 0; n < SLSD_SEG_NUM; n++)
                e[n] = !off_n ? 1'b0 : !lamp_n ? 1'b1 : img[n][c];
            `CHK(cols, e)
            if (role)
                `CHK(align_o, 1'(c != 0))
        end
        repeat (100)
        begin
            @(negedge clk);
            seen = seen | bp[2];
        end
        `CHK(seen, ~half)
    endtask : check_cols

    task automatic tick_period();
        int n;
        n = 0;
        for (int h = 0; h < 3; h++)
            while (tick === h[0] && n < 200)
            begin
                @(negedge clk);
                n = (h == 0) ? 0 : n + 1;
            end
        `CHK(n, 4 * OSC)
    endtask : tick_period

    task automatic complete_run();
        $display("Comparisons %0d, mismatches %0d", compares, error_cnt);
        if (error_cnt == 0 && compares > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask : complete_run

    // =====================================================================
    // Test sequence.
    initial
    begin
        cyc(10);
        rst = 1'b0;
        cyc(1);
        `CHK(loaded, 3'h0)
        frame(72'h5a3c_96e1_f07d_28b4_c1, 1'b0, 3'b111, 72, 1'b0);
        cyc(250);
        `CHK(loaded, 3'h7)
        check_cols(1'b0);
        frame(72'h3_c96e_1f07_d28b_4c15_a, 1'b0, 3'b010, 72, 1'b1);
        cyc(250);
        check_cols(1'b0);
        duty = 1'b1;
        frame(72'h9e_2b71_c4d8_06f3, 1'b1, 3'b011, 48, 1'b0);
        cyc(250);
        check_cols(1'b1);
        frame(72'h71_d40e_9b3a_c562, 1'b1, 3'b100, 44, 1'b0);
        cyc(250);
        check_cols(1'b1);
        for (int t = 0; t < 3; t++)
        begin
            {lamp_n, off_n} = 2'(6'b100100 >> (2 * t));
            cyc(8);
            check_cols(1'b1);
        end
        {lamp_n, off_n} = 2'b11;
        `CHK(align_oe_n, 1'b0)
        tick_period();
        role = 1'b0;
        rc_run = 1'b1;
        cyc(20);
        `CHK(align_oe_n, 1'b1)
        tick_period();
        wait_com(3'h1);
        wait_com(3'h2);
        align_drv = 1'b0;
        cyc(5);
        `CHK(bp, 3'h1)
        align_drv = 1'b1;
        rc_run = 1'b0;
        cyc(20);
        for (int f = 0; f < 9; f++)
        begin
            `CHK(ready, 1'(f < SLSD_FIFO_DEPTH))
            frame({9{8'(f * 37 + 5)}}, 1'b1, 3'(1 << (f % 3)), 48, 1'b0);
        end
        rc_run = 1'b1;
        cyc(900);
        `CHK(ready, 1'b1)
        check_cols(1'b1);
        rst = 1'b1;
        cyc(10);
        rst = 1'b0;
        cyc(1);
        `CHK(loaded, 3'h0)
        complete_run();
    end

    initial
    begin
        cyc(50000);
        error_cnt++;
        complete_run();
    end
endmodule : slsd_top_bench
